// >>> fmd_pkg.sv
// Shared constants for the filter MAC datapath: control word layout and opcodes
package fmd_pkg;
  localparam int DW = 24;
  localparam int AW = 48;
  localparam int RAM_DEPTH = 64;
  localparam int RAM_AW = 6;
  localparam int CTRL_W = 18;
  // Control word field positions, least significant field first
  localparam int F_ACC_LO = 0;
  localparam int F_ACC_W = 2;
  localparam int F_ALU_LO = 2;
  localparam int F_ALU_W = 3;
  localparam int F_ADDR_LO = 5;
  localparam int F_SEL_LO = 11;
  localparam int F_SEL_W = 2;
  localparam int F_SHF_LO = 13;
  localparam int F_SHF_W = 2;
  localparam int F_RND = 15;
  localparam int F_WR_LO = 16;
  localparam int F_WR_W = 2;
  // Slice handed from accumulator to ALU
  localparam int SLICE_HI = 46;
  localparam int SLICE_LO = 23;
  localparam int RND_BIT = 22;
  // Accumulator commands
  localparam logic [1:0] ACC_HOLD = 2'h0;
  localparam logic [1:0] ACC_MAC = 2'h1;
  localparam logic [1:0] ACC_LOAD = 2'h2;
  localparam logic [1:0] ACC_CLR = 2'h3;
  // ALU operations
  localparam logic [2:0] ALU_PASS = 3'h0;
  localparam logic [2:0] ALU_ADD = 3'h1;
  localparam logic [2:0] ALU_SUB = 3'h2;
  localparam logic [2:0] ALU_CMP = 3'h3;
  localparam logic [2:0] ALU_THR = 3'h4;
  localparam logic [2:0] ALU_ABS = 3'h5;
  localparam logic [2:0] ALU_SQL = 3'h6;
  localparam logic [2:0] ALU_SAT = 3'h7;
  // ALU operand A sources
  localparam logic [1:0] SEL_SLICE = 2'h0;
  localparam logic [1:0] SEL_HOLD = 2'h1;
  localparam logic [1:0] SEL_SMP = 2'h2;
  localparam logic [1:0] SEL_COEF = 2'h3;
  // Shifter settings
  localparam logic [1:0] SHF_NONE = 2'h0;
  localparam logic [1:0] SHF_L1 = 2'h1;
  localparam logic [1:0] SHF_R1 = 2'h2;
  localparam logic [1:0] SHF_R2 = 2'h3;
  // Write-back targets
  localparam logic [1:0] WR_NONE = 2'h0;
  localparam logic [1:0] WR_SMP = 2'h1;
  localparam logic [1:0] WR_HOLD = 2'h2;
  localparam logic [1:0] WR_PUSH = 2'h3;
  // Fixed-point limits and reset values
  localparam logic [23:0] FX_MAX = 24'h7fffff;
  localparam logic [23:0] FX_MIN = 24'h800000;
  localparam logic [23:0] FX_ZERO = 24'h000000;
  localparam logic [23:0] FX_ONE_LSB = 24'h000001;
  localparam logic [47:0] ACC_ZERO = 48'h000000000000;
endpackage

// >>> fmd_datapath.sv
// Numeric datapath of the filter accelerator: MAC, ALU, RAMs, stream in and out
`timescale 1ns/100ps
`default_nettype none
module fmd_datapath (
  input wire logic clk,
  input wire logic rst,
  input wire logic [17:0] ctrl,
  input wire logic [23:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic sample_avail,
  input wire logic coef_we,
  input wire logic [5:0] coef_addr,
  input wire logic [23:0] coef_data,
  output logic [23:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic dp_ready,
  output logic cmp_flag
);
  // Control field decode
  // field split
  logic [1:0] acc_op;
  logic [2:0] alu_op;
  logic [5:0] addr;
  logic [1:0] a_sel;
  logic [1:0] shf;
  logic rnd;
  logic [1:0] wr;
  assign acc_op = ctrl[fmd_pkg::F_ACC_LO +: fmd_pkg::F_ACC_W];
  assign alu_op = ctrl[fmd_pkg::F_ALU_LO +: fmd_pkg::F_ALU_W];
  assign addr = ctrl[fmd_pkg::F_ADDR_LO +: fmd_pkg::RAM_AW];
  assign a_sel = ctrl[fmd_pkg::F_SEL_LO +: fmd_pkg::F_SEL_W];
  assign shf = ctrl[fmd_pkg::F_SHF_LO +: fmd_pkg::F_SHF_W];
  assign rnd = ctrl[fmd_pkg::F_RND];
  assign wr = ctrl[fmd_pkg::F_WR_LO +: fmd_pkg::F_WR_W];

  // Sample and coefficient pair storage
  // 64 pairs
  logic [23:0] smp_ram [0:fmd_pkg::RAM_DEPTH-1];
  logic [23:0] coef_ram [0:fmd_pkg::RAM_DEPTH-1];
  logic [23:0] smp_rd;
  logic [23:0] coef_rd;
  assign smp_rd = smp_ram[addr];
  assign coef_rd = coef_ram[addr];

  // Input staging word; one deep so the bus side may run ahead by one sample
  logic [23:0] in_hold;
  logic smp_wr;
  assign smp_wr = (wr == fmd_pkg::WR_SMP) && sample_avail;

  always_ff @(posedge clk) begin
    if (rst) begin
      in_ready <= 1'b1;
      sample_avail <= 1'b0;
      in_hold <= fmd_pkg::FX_ZERO;
    end else if (in_valid && in_ready) begin
      in_hold <= in_data;
      in_ready <= 1'b0;
      sample_avail <= 1'b1;
    end else if (smp_wr) begin
      in_ready <= 1'b1; // Slot freed once the word is in RAM
      sample_avail <= 1'b0;
    end
  end

  // RAM writes; memories carry no reset
  // pair storage writes
  always_ff @(posedge clk) begin
    if (smp_wr) begin
      smp_ram[addr] <= in_hold;
    end
    if (coef_we) begin
      coef_ram[coef_addr] <= coef_data;
    end
  end

  // Signed fractional multiply; Q1.23 times Q1.23 gives Q2.46
  // signed fractions
  logic signed [47:0] prod;
  assign prod = $signed(smp_rd) * $signed(coef_rd);

  // Accumulator, the only wide register in the datapath
  // sole wide register
  logic signed [47:0] acc;
  always_ff @(posedge clk) begin
    if (rst) begin
      acc <= fmd_pkg::ACC_ZERO;
    end else begin
      case (acc_op)
        fmd_pkg::ACC_MAC: acc <= acc + prod;
        fmd_pkg::ACC_LOAD: acc <= prod;
        fmd_pkg::ACC_CLR: acc <= fmd_pkg::ACC_ZERO;
        default: acc <= acc;
      endcase
    end
  end

  // Slice with optional round-half-up; wraps at +max, so pair with SAT if needed
  // accumulator slice
  logic [23:0] slice;
  assign slice = acc[fmd_pkg::SLICE_HI:fmd_pkg::SLICE_LO] +
                 {23'h0, rnd & acc[fmd_pkg::RND_BIT]};

  // Holding register, the ALU's second operand
  logic [23:0] hold;

  // Operand routing and shifter
  // routing and shifting
  logic [23:0] a_raw;
  logic signed [23:0] a_sh;
  logic signed [23:0] b_op;
  always_comb begin
    case (a_sel)
      fmd_pkg::SEL_SLICE: a_raw = slice;
      fmd_pkg::SEL_HOLD: a_raw = hold;
      fmd_pkg::SEL_SMP: a_raw = smp_rd;
      fmd_pkg::SEL_COEF: a_raw = coef_rd;
      default: a_raw = slice;
    endcase
    case (shf)
      fmd_pkg::SHF_L1: a_sh = {a_raw[22:0], 1'b0};
      fmd_pkg::SHF_R1: a_sh = $signed(a_raw) >>> 1;
      fmd_pkg::SHF_R2: a_sh = $signed(a_raw) >>> 2;
      default: a_sh = a_raw;
    endcase
    b_op = hold;
  end

  // ALU; add and subtract wrap, SAT clamps A into [-B, B]
  // ALU operations
  logic signed [23:0] alu_res;
  logic signed [23:0] a_abs;
  logic signed [23:0] b_neg;
  always_comb begin
    a_abs = a_sh;
    if (a_sh == $signed(fmd_pkg::FX_MIN)) begin
      a_abs = fmd_pkg::FX_MAX; // Negating the minimum would overflow
    end else if (a_sh < 0) begin
      a_abs = -a_sh;
    end
    b_neg = -b_op;
    case (alu_op)
      fmd_pkg::ALU_ADD: alu_res = a_sh + b_op;
      fmd_pkg::ALU_SUB: alu_res = a_sh - b_op;
      fmd_pkg::ALU_CMP: alu_res = (a_sh > b_op) ? fmd_pkg::FX_ONE_LSB : fmd_pkg::FX_ZERO;
      fmd_pkg::ALU_THR: alu_res = (a_sh >= b_op) ? a_sh : fmd_pkg::FX_ZERO;
      fmd_pkg::ALU_ABS: alu_res = a_abs;
      fmd_pkg::ALU_SQL: alu_res = (a_abs < b_op) ? fmd_pkg::FX_ZERO : a_sh;
      fmd_pkg::ALU_SAT: begin
        if (a_sh > b_op) begin
          alu_res = b_op;
        end else if (a_sh < b_neg) begin
          alu_res = b_neg;
        end else begin
          alu_res = a_sh;
        end
      end
      default: alu_res = a_sh;
    endcase
  end

  // Holding register and compare flag
  // holding
  always_ff @(posedge clk) begin
    if (rst) begin
      hold <= fmd_pkg::FX_ZERO;
    end else if (wr == fmd_pkg::WR_HOLD) begin
      hold <= alu_res;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cmp_flag <= 1'b0;
    end else if (alu_op == fmd_pkg::ALU_CMP) begin
      cmp_flag <= (a_sh > b_op);
    end
  end

  // Two-entry result buffer: head drives the port, spare absorbs a stalled cycle
  logic [23:0] sp_data;
  logic sp_valid;
  logic pop;
  logic push;
  logic [23:0] next_out_data;
  logic next_out_valid;
  logic [23:0] next_sp_data;
  logic next_sp_valid;
  assign pop = out_valid && out_ready;
  assign push = (wr == fmd_pkg::WR_PUSH) && dp_ready;

  always_comb begin
    next_out_data = out_data;
    next_out_valid = out_valid;
    next_sp_data = sp_data;
    next_sp_valid = sp_valid;
    if (pop) begin
      next_out_data = sp_data;
      next_out_valid = sp_valid;
      next_sp_valid = 1'b0;
    end
    if (push) begin
      if (!next_out_valid) begin
        next_out_data = alu_res;
        next_out_valid = 1'b1;
      end else begin
        next_sp_data = alu_res;
        next_sp_valid = 1'b1;
      end
    end
  end

  // dp_ready tells the sequencer a push will be taken next cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      out_data <= fmd_pkg::FX_ZERO;
      out_valid <= 1'b0;
      sp_data <= fmd_pkg::FX_ZERO;
      sp_valid <= 1'b0;
      dp_ready <= 1'b1;
    end else begin
      out_data <= next_out_data;
      out_valid <= next_out_valid;
      sp_data <= next_sp_data;
      sp_valid <= next_sp_valid;
      dp_ready <= !next_sp_valid;
    end
  end

  // Checks on the datapath
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_MAC_SUM: assert property (
    acc_op == fmd_pkg::ACC_MAC |=> acc == $past(acc) + $past(prod))
    else $error("accumulator did not add the product");

  AST_MAC_LOAD: assert property (
    acc_op == fmd_pkg::ACC_LOAD |=> acc == $past(prod))
    else $error("accumulator load lost the product");

  AST_MAC_CLEAR: assert property (
    acc_op == fmd_pkg::ACC_CLR |=> acc == fmd_pkg::ACC_ZERO)
    else $error("accumulator not cleared");

  AST_ACC_HOLD: assert property (
    acc_op == fmd_pkg::ACC_HOLD |=> $stable(acc))
    else $error("accumulator moved without command");

  AST_SLICE_OUT: assert property (
    push && !out_valid && a_sel == fmd_pkg::SEL_SLICE && shf == fmd_pkg::SHF_NONE
    && !rnd && alu_op == fmd_pkg::ALU_PASS
    |=> out_valid && out_data == $past(acc[fmd_pkg::SLICE_HI:fmd_pkg::SLICE_LO]))
    else $error("output is not accumulator bits 46:23");

  AST_ABS_POS: assert property (
    alu_op == fmd_pkg::ALU_ABS |-> !alu_res[23])
    else $error("absolute value came out negative");

  AST_SQL_ZERO: assert property (
    alu_op == fmd_pkg::ALU_SQL && alu_res != fmd_pkg::FX_ZERO |-> alu_res == a_sh)
    else $error("squelch altered a passing value");

  AST_HOLD_WR: assert property (
    wr == fmd_pkg::WR_HOLD |=> hold == $past(alu_res))
    else $error("holding register missed its write");

  AST_SMP_WR: assert property (
    smp_wr |=> smp_ram[$past(addr)] == $past(in_hold) && in_ready)
    else $error("sample not stored or slot not freed");

  AST_OUT_STALL: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled result changed or vanished");

  AST_SAT_RANGE: assert property (
    alu_op == fmd_pkg::ALU_SAT && !b_op[23] |-> alu_res <= b_op && alu_res >= b_neg)
    else $error("saturation left the limit range");

  AST_SMP_TAKE: assert property (
    in_valid && in_ready |=> sample_avail && !in_ready)
    else $error("offered sample not staged");

  AST_BUF_ORDER: assert property (
    pop && sp_valid |=> out_valid && out_data == $past(sp_data))
    else $error("spare result lost its place in line");
endmodule
`default_nettype wire

// >>> fmd_bus_model.sv
// System-side bus model: offers samples to the datapath and takes its results
`timescale 1ns/100ps
`default_nettype none
module fmd_bus_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic send,
  input wire logic [23:0] send_data,
  input wire logic stall,
  input wire logic in_ready,
  input wire logic out_valid,
  output logic [23:0] in_data,
  output logic in_valid,
  output logic out_ready,
  output logic got
);
  // sample delivery
  // Word holds until taken or replaced by a new send; then the bus shows inverted data, never a stale copy
  always_ff @(posedge clk) begin
    if (rst) begin
      in_valid <= 1'b0;
      in_data <= 24'h000000;
    end else if (in_valid && in_ready) begin
      in_valid <= 1'b0;
      in_data <= ~in_data;
    end else if (send) begin
      in_valid <= 1'b1;
      in_data <= send_data;
    end
  end
  // result take-up
  // Stall lets the bench fill the result buffer
  assign out_ready = ~stall;
  assign got = out_valid & out_ready;
endmodule
`default_nettype wire

// >>> filter_mac_datapath_tb_top.sv
// Self-checking bench for the filter MAC datapath
`timescale 1ns/100ps
`default_nettype none
module filter_mac_datapath_tb_top;
  logic clk, rst, in_valid, in_ready, sample_avail, coef_we, out_valid, out_ready;
  logic dp_ready, cmp_flag, send, stall, got;
  logic [17:0] ctrl;
  logic [23:0] in_data, coef_data, out_data, send_data;
  logic [5:0] coef_addr;
  logic [23:0] rq[$];
  int err_count = 0;
  int checks_done = 0;
  fmd_datapath u_dut (.clk(clk), .rst(rst), .ctrl(ctrl), .in_data(in_data),
    .in_valid(in_valid), .in_ready(in_ready), .sample_avail(sample_avail),
    .coef_we(coef_we), .coef_addr(coef_addr), .coef_data(coef_data),
    .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
    .dp_ready(dp_ready), .cmp_flag(cmp_flag));
  fmd_bus_model u_bus (.clk(clk), .rst(rst), .send(send), .send_data(send_data),
    .stall(stall), .in_ready(in_ready), .out_valid(out_valid), .in_data(in_data),
    .in_valid(in_valid), .out_ready(out_ready), .got(got));
  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Popped results wait here, in order, for the checks
  always @(posedge clk) begin
    if (got === 1'b1) rq.push_back(out_data);
  end
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [17:0] mk(input logic [1:0] ac, input logic [2:0] op,
      input logic [5:0] ad, input logic [1:0] sl, input logic rn, input logic [1:0] wr);
    return {wr, rn, fmd_pkg::SHF_NONE, sl, ad, op, ac};
  endfunction
  function automatic logic [23:0] alu_exp(input logic [2:0] op, input logic signed [23:0] a);
    logic signed [23:0] b = 24'sh100000;
    case (op)
      fmd_pkg::ALU_ADD: return a + b;
      fmd_pkg::ALU_SUB: return a - b;
      fmd_pkg::ALU_THR: return (a >= b) ? a : 24'h000000;
      fmd_pkg::ALU_ABS: return (a < 0) ? -a : a;
      fmd_pkg::ALU_SQL: return (((a < 0) ? -a : a) < b) ? 24'h000000 : a;
      fmd_pkg::ALU_SAT: return (a > b) ? b : ((a < -b) ? -b : a);
      default: return a;
    endcase
  endfunction
  task automatic step(input logic [17:0] c);
    @(posedge clk);
    ctrl <= c;
  endtask
  task automatic mac(input logic [1:0] c, input logic [5:0] ad);
    step(mk(c, fmd_pkg::ALU_PASS, ad, fmd_pkg::SEL_SLICE, 1'b0, fmd_pkg::WR_NONE));
  endtask
  task automatic push(input logic [1:0] sl, input logic [2:0] op, input logic [5:0] ad,
      input logic rn);
    step(mk(fmd_pkg::ACC_HOLD, op, ad, sl, rn, fmd_pkg::WR_PUSH));
    step('0);
  endtask
  task automatic coef(input logic [5:0] a, input logic [23:0] d);
    @(posedge clk);
    coef_we <= 1'b1;
    coef_addr <= a;
    coef_data <= d;
    @(posedge clk);
    coef_we <= 1'b0;
  endtask
  // Offer one sample, wait for the staging slot, then write it to sample RAM
  task automatic smp(input logic [5:0] a, input logic [23:0] d);
    @(posedge clk);
    send <= 1'b1;
    send_data <= d;
    @(posedge clk);
    send <= 1'b0;
    for (int i = 0; i < 8 && sample_avail !== 1'b1; i++) @(negedge clk);
    chk({22'h0, sample_avail, in_ready}, 24'h000002);
    step(mk(fmd_pkg::ACC_HOLD, fmd_pkg::ALU_PASS, a, fmd_pkg::SEL_SLICE, 1'b0,
      fmd_pkg::WR_SMP));
    step('0);
  endtask
  task automatic want(input logic [23:0] e);
    for (int i = 0; i < 20 && rq.size() == 0; i++) @(negedge clk);
    if (rq.size() == 0) chk(24'hxxxxxx, e);
    else chk(rq.pop_front(), e);
  endtask
  task automatic t_reset();
    @(negedge clk);
    chk({18'h0, in_ready, sample_avail, out_valid, dp_ready, cmp_flag, 1'b0}, 24'h000024);
    chk(out_data, fmd_pkg::FX_ZERO);
    $display("reset test done");
  endtask
  // back-to-back MACs over both ends of the storage
  task automatic t_mac();
    logic signed [47:0] acc;
    coef(6'h00, 24'h200000);
    coef(6'h3f, 24'h100001);
    smp(6'h00, 24'h400000);
    smp(6'h3f, 24'hc00000);
    acc = $signed(24'h400000) * $signed(24'h200000);
    acc = acc + $signed(24'hc00000) * $signed(24'h100001);
    mac(fmd_pkg::ACC_CLR, 6'h00);
    mac(fmd_pkg::ACC_MAC, 6'h00);
    mac(fmd_pkg::ACC_MAC, 6'h3f);
    push(fmd_pkg::SEL_SLICE, fmd_pkg::ALU_PASS, 6'h00, 1'b1);
    want(acc[46:23] + acc[22]);
    mac(fmd_pkg::ACC_LOAD, 6'h00);
    push(fmd_pkg::SEL_SLICE, fmd_pkg::ALU_PASS, 6'h00, 1'b0);
    acc = $signed(24'h400000) * $signed(24'h200000);
    want(acc[46:23]);
    $display("mac test done");
  endtask
  task automatic t_alu();
    logic signed [23:0] av [3] = '{24'h123456, 24'he00000, 24'h000100};
    coef(6'h04, 24'h100000);
    for (int k = 0; k < 3; k++) coef(6'(k + 1), av[k]);
    step(mk(fmd_pkg::ACC_HOLD, fmd_pkg::ALU_PASS, 6'h04, fmd_pkg::SEL_COEF, 1'b0,
      fmd_pkg::WR_HOLD));
    for (int k = 0; k < 3; k++) begin
      for (int op = 0; op < 8; op++) begin
        if (3'(op) == fmd_pkg::ALU_CMP) begin
          step(mk(fmd_pkg::ACC_HOLD, 3'(op), 6'(k + 1), fmd_pkg::SEL_COEF, 1'b0, 2'h0));
          step('0);
          @(negedge clk);
          chk({23'h0, cmp_flag}, {23'h0, av[k] > 24'sh100000});
        end else begin
          push(fmd_pkg::SEL_COEF, 3'(op), 6'(k + 1), 1'b0);
          want(alu_exp(3'(op), av[k]));
        end
      end
    end
    $display("alu test done");
  endtask
  // Receiver stalls while two results are pushed back to back
  task automatic t_buf();
    @(posedge clk);
    stall <= 1'b1;
    step(mk(fmd_pkg::ACC_HOLD, fmd_pkg::ALU_PASS, 6'h00, fmd_pkg::SEL_COEF, 1'b0,
      fmd_pkg::WR_PUSH));
    push(fmd_pkg::SEL_COEF, fmd_pkg::ALU_PASS, 6'h3f, 1'b0);
    @(negedge clk);
    chk({22'h0, dp_ready, out_valid}, 24'h000001);
    @(posedge clk);
    stall <= 1'b0;
    want(24'h200000);
    want(24'h100001);
    $display("buffer test done");
  endtask
  // Holding register as operand A, then every shifter setting on a negative sample
  task automatic t_shift();
    logic [23:0] ex [4] = '{24'hc00000, 24'h800000, 24'he00000, 24'hf00000};
    push(fmd_pkg::SEL_HOLD, fmd_pkg::ALU_PASS, 6'h00, 1'b0);
    want(24'h100000);
    for (int s = 0; s < 4; s++) begin
      step(mk(fmd_pkg::ACC_HOLD, fmd_pkg::ALU_PASS, 6'h3f, fmd_pkg::SEL_SMP, 1'b0,
        fmd_pkg::WR_PUSH) | {3'h0, 2'(s), 13'h0});
      step('0);
      want(ex[s]);
    end
    $display("shift test done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    ctrl = '0;
    coef_we = 1'b0;
    coef_addr = '0;
    coef_data = '0;
    send = 1'b0;
    send_data = '0;
    stall = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_mac();
    t_alu();
    t_shift();
    t_buf();
    final_report();
  end
  // Whole run needs well under 2000 cycles
  initial begin
    #20000;
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire
